// >>> design/pirs_cfg.svh
`ifndef PIRS_CFG_SVH
`define PIRS_CFG_SVH
// Index selector values and host address for the indexed registers
`define PIRS_IDX_SER0      3'h2
`define PIRS_IDX_SER1      3'h3
`define PIRS_IDX_PRN       3'h4
`define PIRS_IDX_REV       3'h6
`define PIRS_ADDR_DATA     3'h7
// Route select field and codes
`define PIRS_CODE_MSB      3
`define PIRS_CODE_OFF      4'h0
`define PIRS_CODE_MAX      4'h9
`define PIRS_CODE_ALONE    4'hf
`define PIRS_RESET_VAL     8'h00
// Gate bits inside the port control registers
`define PIRS_MODEM_LOOP_BIT 4
`define PIRS_MODEM_EN_BIT   3
`define PIRS_PCR_IRQ_BIT   4
// Mux input positions (code minus one) and line count
`define PIRS_NLINES        9
`define PIRS_LN_IRQ3       0
`define PIRS_LN_IRQ4       1
`define PIRS_LN_IRQ5       2
`define PIRS_LN_IRQ6       3
`define PIRS_LN_IRQ7       4
`define PIRS_LN_IRQ10      5
`define PIRS_LN_IRQ11      6
`define PIRS_LN_BOOT_ROM   7
`define PIRS_LN_IRQ15      8
`endif

// >>> design/pirs_pkg.sv
`default_nettype none
package pirs_pkg;
   // Host register access bundle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [2:0] idx;
      logic [7:0] wdata;
   } pirs_host_t;
   // Raw interrupt request inputs sampled by the mux
   typedef struct packed {
      logic irq3, irq4, irq5, irq6, irq7, irq8, irq9, irq10;
      logic irq11, irq12, irq14, irq15, kbint, a20gt, rescpu, boot_rom_width_in;
   } pirs_irqs_t;
endpackage
`default_nettype wire

// >>> design/pirs_top.sv
`include "pirs_cfg.svh"
`default_nettype none
module pirs_top #(
   parameter logic [7:0] REVISION = 8'h05 // Arbitrary revision number
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire pirs_pkg::pirs_host_t host,
   output logic [7:0]             rd_data,
   input  wire logic [7:0]        modem_control_reg0,
   input  wire logic [7:0]        modem_control_reg1,
   input  wire logic              printer_irq_gate,
   input  wire logic              serial0_irq,
   input  wire logic              serial1_irq,
   input  wire logic              printer_irq,
   input  wire pirs_pkg::pirs_irqs_t irq_in,
   input  wire logic [2:0]        mux_sequence_ctrl,
   output logic                   muxed_irq_out_a,
   output logic                   muxed_irq_out_b,
   output logic                   stand_alone
);
   // Route registers and read-back
   logic [7:0]  serial0_route_code_r;
   logic [7:0]  serial1_route_code_r;
   logic [7:0]  printer_route_code_r;
   logic [7:0]  rd_data_r;
   logic [7:0]  rd_data_nxt;
   // Synchroniser stages for pin-side inputs
   logic [15:0] irq_meta_r;
   logic [15:0] irq_sync_r;
   logic [2:0]  seq_meta_r;
   logic [2:0]  seq_sync_r;
   logic [2:0]  src_meta_r;
   logic [2:0]  src_sync_r;
   // Registered outputs
   logic        out_a_r;
   logic        out_b_r;
   logic        alone_r;

   // Register decode
   wire at_data  = host.addr == `PIRS_ADDR_DATA;
   wire sel_ser0 = at_data && host.idx == `PIRS_IDX_SER0;
   wire sel_ser1 = at_data && host.idx == `PIRS_IDX_SER1;
   wire sel_prn  = at_data && host.idx == `PIRS_IDX_PRN;
   wire sel_rev  = at_data && host.idx == `PIRS_IDX_REV;

   // Write strobes; the revision register has none, so writes there are dropped
   wire wr_ser0  = host.wr && sel_ser0;
   wire wr_ser1  = host.wr && sel_ser1;
   wire wr_prn   = host.wr && sel_prn;

   // Route registers, cleared by reset; reserved upper bits are kept as written
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         serial0_route_code_r <= `PIRS_RESET_VAL;
         serial1_route_code_r <= `PIRS_RESET_VAL;
         printer_route_code_r <= `PIRS_RESET_VAL;
      end else begin
         if (wr_ser0) serial0_route_code_r <= host.wdata;
         if (wr_ser1) serial1_route_code_r <= host.wdata;
         if (wr_prn)  printer_route_code_r <= host.wdata;
      end
   end

   // Revision readback is the complement of the revision number
   localparam logic [7:0] REV_READBACK = ~REVISION;

   // Read data select; unmapped indices read zero, no read keeps the last value
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (host.rd) begin
         if (sel_ser0)      rd_data_nxt = serial0_route_code_r;
         else if (sel_ser1) rd_data_nxt = serial1_route_code_r;
         else if (sel_prn)  rd_data_nxt = printer_route_code_r;
         else if (sel_rev)  rd_data_nxt = REV_READBACK;
         else               rd_data_nxt = `PIRS_RESET_VAL;
      end
   end

   // Read data register, held until the next read
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data_r <= `PIRS_RESET_VAL;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // Port interrupts gathered for one synchroniser
   wire [2:0] src_raw = {serial0_irq, serial1_irq, printer_irq};

   // Two-flop synchroniser for the raw interrupt pins
   always_ff @(posedge ref_clk) begin
      irq_meta_r <= irq_in;
      irq_sync_r <= irq_meta_r;
   end

   // Two-flop synchroniser for the sequencing control
   always_ff @(posedge ref_clk) begin
      seq_meta_r <= mux_sequence_ctrl;
      seq_sync_r <= seq_meta_r;
   end

   // Two-flop synchroniser for the port interrupts
   always_ff @(posedge ref_clk) begin
      src_meta_r <= src_raw;
      src_sync_r <= src_meta_r;
   end

   // Synchronised port interrupts by name
   wire ser0_irq_s;
   wire ser1_irq_s;
   wire prn_irq_s;
   assign {ser0_irq_s, ser1_irq_s, prn_irq_s} = src_sync_r;

   // Synchronised pins viewed as the named bundle
   pirs_pkg::pirs_irqs_t irqs;
   assign irqs = irq_sync_r;

   // Source gating; control bits come from same-clock logic, so no synchroniser
   wire ser0_en = !modem_control_reg0[`PIRS_MODEM_LOOP_BIT] &&
                  modem_control_reg0[`PIRS_MODEM_EN_BIT];
   wire ser1_en = !modem_control_reg1[`PIRS_MODEM_LOOP_BIT] &&
                  modem_control_reg1[`PIRS_MODEM_EN_BIT];
   wire prn_en  = printer_irq_gate;

   // Route select fields
   wire [3:0] c0 = serial0_route_code_r[`PIRS_CODE_MSB:0];
   wire [3:0] c1 = serial1_route_code_r[`PIRS_CODE_MSB:0];
   wire [3:0] cp = printer_route_code_r[`PIRS_CODE_MSB:0];

   // All ones in the serial 0 field puts both serial ports into stand-alone
   wire alone = c0 == `PIRS_CODE_ALONE;

   // Raw lines in code order 1..9
   wire [`PIRS_NLINES-1:0] raw_line = {irqs.irq15, irqs.boot_rom_width_in, irqs.irq11,
                                        irqs.irq10, irqs.irq7, irqs.irq6, irqs.irq5,
                                        irqs.irq4, irqs.irq3};
   wire [`PIRS_NLINES-1:0] line;

   // Per-line substitution with printer over serial 1 over serial 0.
   // Reserved codes match no line, so they substitute nothing.
   genvar g;
   generate
      for (g = 0; g < `PIRS_NLINES; g++) begin : g_line
         localparam logic [3:0] CODE = 4'(g + 1);
         wire hit0 = ser0_en && c0 == CODE;
         wire hit1 = ser1_en && c1 == CODE;
         wire hitp = prn_en && cp == CODE;
         assign line[g] = hitp ? prn_irq_s :
                          hit1 ? ser1_irq_s :
                          hit0 ? ser0_irq_s : raw_line[g];
      end
   endgenerate

   // Sequencing mux for the two outputs
   logic mux_a;
   logic mux_b;
   always_comb begin
      case (seq_sync_r)
         3'h0: begin
            mux_a = irqs.irq8;
            mux_b = irqs.irq12;
         end
         3'h1: begin
            mux_a = irqs.irq9;
            mux_b = irqs.kbint;
         end
         3'h2: begin
            mux_a = line[`PIRS_LN_IRQ10];
            mux_b = irqs.a20gt;
         end
         3'h3: begin
            mux_a = line[`PIRS_LN_IRQ11];
            mux_b = line[`PIRS_LN_IRQ3];
         end
         3'h4: begin
            mux_a = line[`PIRS_LN_BOOT_ROM];
            mux_b = line[`PIRS_LN_IRQ4];
         end
         3'h5: begin
            mux_a = irqs.rescpu;
            mux_b = line[`PIRS_LN_IRQ5];
         end
         3'h6: begin
            mux_a = irqs.irq14;
            mux_b = line[`PIRS_LN_IRQ6];
         end
         3'h7: begin
            mux_a = line[`PIRS_LN_IRQ15];
            mux_b = line[`PIRS_LN_IRQ7];
         end
         default: begin
            mux_a = 1'b0;
            mux_b = 1'b0;
         end
      endcase
   end

   // Stand-alone bypasses the mux and feeds the serial interrupts straight out
   wire out_a_nxt = alone ? ser0_irq_s : mux_a;
   wire out_b_nxt = alone ? ser1_irq_s : mux_b;

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_a_r <= 1'b0;
         out_b_r <= 1'b0;
         alone_r <= 1'b0;
      end else begin
         out_a_r <= out_a_nxt;
         out_b_r <= out_b_nxt;
         alone_r <= alone;
      end
   end

   // Top-level outputs straight from their flip-flops
   assign muxed_irq_out_a = out_a_r;
   assign muxed_irq_out_b = out_b_r;
   assign stand_alone     = alone_r;
   assign rd_data         = rd_data_r;
endmodule
`default_nettype wire

// >>> testbench/pirs_chk.sv
`default_nettype none
module pirs_chk #(
   parameter logic [7:0] REVISION = 8'h05
) (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire pirs_pkg::pirs_host_t host,
   input wire logic [7:0]           rd_data,
   input wire logic                 serial0_irq,
   input wire logic                 serial1_irq,
   input wire logic                 muxed_irq_out_a,
   input wire logic                 muxed_irq_out_b,
   input wire logic                 stand_alone
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Access aimed at the indexed data address
   wire at_data = host.addr == 3'h7;
   a_rev_read: assert property (host.rd && at_data && host.idx == 3'h6 |=> rd_data == ~REVISION)
      else $error("revision readback wrong");
   a_unmapped_zero: assert property (host.rd && at_data && host.idx == 3'h5 |=> !rd_data)
      else $error("unmapped read not zero");
   a_rd_hold: assert property (!host.rd |=> $stable(rd_data))
      else $error("read data moved without a read");
   a_alone_set: assert property (host.wr && at_data && host.idx == 3'h2 |=> ##1
      stand_alone == ($past(host.wdata[3:0], 2) == 4'hf)) else $error("stand-alone flag wrong");
   a_alone_steady: assert property (!(host.wr && at_data && host.idx == 3'h2) [*3]
      |=> $stable(stand_alone)) else $error("stand-alone moved without serial 0 write");
   a_alone_out_a: assert property (stand_alone [*5] |-> muxed_irq_out_a == $past(serial0_irq, 3))
      else $error("output a not serial 0 in stand-alone");
   a_alone_out_b: assert property (stand_alone [*5] |-> muxed_irq_out_b == $past(serial1_irq, 3))
      else $error("output b not serial 1 in stand-alone");
   a_reset_clear: assert property ($fell(rst) |-> !stand_alone && !muxed_irq_out_a && !rd_data)
      else $error("state not cleared by reset");
   c_alone: cover property (stand_alone);
   c_out_a: cover property (muxed_irq_out_a);
   c_out_b: cover property (muxed_irq_out_b);
endmodule
`default_nettype wire

// >>> testbench/pirs_at_model.sv
`default_nettype none
module pirs_at_model (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   input  wire logic  out_a,
   input  wire logic  out_b,
   output logic [2:0] seq,
   output logic [7:0] got_a,
   output logic [7:0] got_b
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] d1, d2, d3;
   // Step the slot each cycle, file each sample three cycles later under its slot
   always @(posedge ref_clk) begin
      if (rst)
         seq <= 3'h0;
      else
         seq <= seq + 3'h1;
      {d3, d2, d1} <= {d2, d1, seq};
      got_a[d3] <= out_a;
      got_b[d3] <= out_b;
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] REV = 8'h05; // Arbitrary revision number
   localparam int POS [10] = '{0, 3, 4, 5, 6, 7, 10, 11, 12, 15};
   logic ref_clk = 1'b0, rst = 1'b1, s0 = 1'b0, s1 = 1'b0, pp = 1'b0, pg = 1'b1;
   logic [7:0] m0 = 8'h08, m1 = 8'h08, rd_data, ga, gb;
   logic [2:0] seq;
   logic out_a, out_b, alone;
   pirs_pkg::pirs_host_t host = '0;
   pirs_pkg::pirs_irqs_t irqs = '1;
   int miscompares = 0, compares = 0;
   pirs_top #(.REVISION(REV)) pirs_top_inst (.ref_clk, .rst, .host, .rd_data,
      .modem_control_reg0(m0), .modem_control_reg1(m1), .printer_irq_gate(pg),
      .serial0_irq(s0), .serial1_irq(s1), .printer_irq(pp), .irq_in(irqs),
      .mux_sequence_ctrl(seq), .muxed_irq_out_a(out_a), .muxed_irq_out_b(out_b),
      .stand_alone(alone));
   pirs_at_model pirs_at_model_inst (.ref_clk, .rst, .out_a, .out_b, .seq, .got_a(ga),
      .got_b(gb));
   initial forever #12.5 ref_clk = ~ref_clk;
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One host access, one cycle long
   task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
      @(negedge ref_clk);
      host = '{w, !w, 3'h7, idx, d};
      @(negedge ref_clk);
      host = '0;
   endtask
   task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(16'(rd_data), 16'(exp));
   endtask
   // Program all three routes with upper bits zero, then compare both outputs in all eight slots
   task automatic route(input logic [3:0] c0, c1, c2, input logic [15:0] exp);
      bus(1'b1, 3'h2, {4'h0, c0});
      bus(1'b1, 3'h3, {4'h0, c1});
      bus(1'b1, 3'h4, {4'h0, c2});
      repeat (16) @(negedge ref_clk);
      chk({ga, gb}, exp);
   endtask
   task automatic test_done;
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 2; i <= 4; i++)
         rdc(3'(i), 8'h00);
      bus(1'b1, 3'h6, 8'h5a);
      rdc(3'h6, ~REV);
      rdc(3'h5, 8'h00);
      route(4'h0, 4'h0, 4'h0, 16'hffff);
      for (int c = 1; c <= 9; c++) begin
         route(4'(c), 4'h0, 4'h0, ~(16'h1 << POS[c]));
         rdc(3'h2, 8'(c));
         route(4'h0, 4'(c), 4'h0, ~(16'h1 << POS[c]));
         rdc(3'h3, 8'(c));
         route(4'h0, 4'h0, 4'(c), ~(16'h1 << POS[c]));
         rdc(3'h4, 8'(c));
      end
      irqs = '0;
      s0 = 1'b1;
      s1 = 1'b1;
      pp = 1'b1;
      route(4'h1, 4'h2, 4'h9, 16'h8018);
      m0 = 8'h18;
      route(4'h1, 4'h2, 4'h9, 16'h8010);
      m1 = 8'h00;
      route(4'h1, 4'h2, 4'h9, 16'h8000);
      pg = 1'b0;
      route(4'h1, 4'h2, 4'h9, 16'h0000);
      {m0, m1, pg, s1} = {8'h08, 8'h08, 1'b1, 1'b0};
      route(4'h5, 4'h5, 4'h0, 16'h0000);
      {s1, pp} = 2'b10;
      route(4'h5, 4'h5, 4'h5, 16'h0000);
      s1 = 1'b0;
      route(4'hf, 4'h0, 4'h0, 16'hff00);
      chk(16'(alone), 16'h0001);
      {s0, s1} = 2'b01;
      route(4'hf, 4'h0, 4'h0, 16'h00ff);
      route(4'h0, 4'h9, 4'h0, 16'h8000);
      chk(16'(alone), 16'h0000);
      test_done();
   end
endmodule
bind pirs_top pirs_chk #(.REVISION(REVISION)) pirs_chk_inst (
   .ref_clk         (ref_clk),
   .rst             (rst),
   .host            (host),
   .rd_data         (rd_data),
   .serial0_irq     (serial0_irq),
   .serial1_irq     (serial1_irq),
   .muxed_irq_out_a (muxed_irq_out_a),
   .muxed_irq_out_b (muxed_irq_out_b),
   .stand_alone     (stand_alone)
);
`default_nettype wire
